// ===== hdl/mvwp_pkg.sv
package mvwp_pkg;
    localparam int          MVWP_CONN_NUM    = 2;
    localparam int          MVWP_CHAN_NUM    = 8;
    localparam int          MVWP_ADDR_W      = 16;
    // map bases and addresses in 16-bit register units
    localparam logic [15:0] MVWP_AIN_BASE    = 16'h0000;
    localparam logic [15:0] MVWP_CNT32_BASE  = 16'h0080;
    localparam logic [15:0] MVWP_TIME_ADDR   = 16'h0090;
    localparam logic [15:0] MVWP_CNT64_BASE  = 16'h00C0;
    localparam logic [15:0] MVWP_FLT_BASE    = 16'h0100;
    localparam logic [15:0] MVWP_UNDEF_WORD  = 16'h0000;
    localparam logic [15:0] MVWP_ZERO_WORD   = 16'h0000;
    localparam logic [1:0]  MVWP_TIME_SLOT   = 2'h2;

    // value formats carried per map region
    typedef enum logic [2:0] {
        MVWP_FMT_SIGNED_WORD,
        MVWP_FMT_UNSIGNED_DOUBLE,
        MVWP_FMT_UNSIGNED_QUAD,
        MVWP_FMT_FLOAT,
        MVWP_FMT_NONE
    } mvwp_fmt_e;

    // one read command from a client connection
    typedef struct packed {
        logic        start;
        logic        word;
        logic [15:0] addr;
    } mvwp_req_s;

    // one returned register
    typedef struct packed {
        logic        valid;
        logic [15:0] data;
    } mvwp_rsp_s;
endpackage

// ===== hdl/mvwp_packer.sv
// How it works
// R01 - The block only answers reads from a client and never starts traffic.
// R02 - Nothing leaves the block unless a client request asks for a register.
// R03 - Two client connections are served at once, each with its own snapshot and reply path.
// R04 - A single register holds a 16-bit value, signed ones in two's complement.
// R05 - 32-bit values put bits 31:16 at the lower address and 15:0 at the next.
// R06 - 64-bit values occupy four registers from bits 63:48 down to 15:0.
// R07 - Floats are IEEE-754 single words split high half first.
// R08 - Time is an unsigned 32-bit seconds count offered as integer only.
// R09 - Every other quantity appears in integer and float form.
// R10 - The client applies scale and offset to integers; floats come scaled.
// R11 - The client should read both halves of a 32-bit value in one command.
// R12 - The client should read all four words of a 64-bit value in one command.
// R13 - The top word of every 64-bit counter reads as zero, giving 48 bits.
// R14 - Addresses outside the map return an arbitrary fixed word.
// R15 - All values are snapshotted when a command starts and served from that copy.
`timescale 1ns/1ps
`default_nettype none
module mvwp_packer
    import mvwp_pkg::*;
(
    input  wire logic                    clk_in,
    input  wire logic                    rst_b_in,
    input  wire logic [15:0]             ain_in   [MVWP_CHAN_NUM],
    input  wire logic [47:0]             count_in [MVWP_CHAN_NUM],
    input  wire logic [31:0]             ain_flt_in   [MVWP_CHAN_NUM],
    input  wire logic [31:0]             count_flt_in [MVWP_CHAN_NUM],
    input  wire logic [31:0]             time_in,
    input  wire mvwp_req_s               req_in   [MVWP_CONN_NUM],
    output mvwp_rsp_s                    rsp_out  [MVWP_CONN_NUM]
);
    // per-connection snapshot copies so one client never disturbs another [R03]
    logic [15:0] snap_ain   [MVWP_CONN_NUM][MVWP_CHAN_NUM];
    logic [47:0] snap_cnt   [MVWP_CONN_NUM][MVWP_CHAN_NUM];
    logic [31:0] snap_aflt  [MVWP_CONN_NUM][MVWP_CHAN_NUM];
    logic [31:0] snap_cflt  [MVWP_CONN_NUM][MVWP_CHAN_NUM];
    logic [31:0] snap_time  [MVWP_CONN_NUM];
    mvwp_rsp_s   next_rsp   [MVWP_CONN_NUM];

    // word selection from the connection's snapshot or, on command start, the live inputs, big-endian packing
    function automatic logic [15:0] pick_word(
        input logic [15:0] addr,
        input logic [15:0] a   [MVWP_CHAN_NUM],
        input logic [47:0] c   [MVWP_CHAN_NUM],
        input logic [31:0] af  [MVWP_CHAN_NUM],
        input logic [31:0] cf  [MVWP_CHAN_NUM],
        input logic [31:0] t
    );
        logic [15:0] w;
        logic [15:0] off;
        logic [2:0]  ch;
        w = MVWP_UNDEF_WORD; // unmapped addresses read a fixed filler [R14]
        off = 16'h0000;
        ch = 3'h0;
        if (addr < MVWP_AIN_BASE + 16'(MVWP_CHAN_NUM))
        begin
            ch = addr[2:0];
            w = a[ch]; // signed word passes as two's complement [R04]
        end
        else if (addr >= MVWP_CNT32_BASE && addr < MVWP_TIME_ADDR)
        begin
            off = addr - MVWP_CNT32_BASE;
            ch = off[3:1];
            w = off[0] ? c[ch][15:0] : c[ch][31:16]; // high half first [R05]
        end
        else if (addr >= MVWP_TIME_ADDR && addr < MVWP_TIME_ADDR + 16'h0002)
        begin
            w = addr[0] ? t[15:0] : t[31:16]; // unsigned seconds, no float copy [R08] [R05]
        end
        else if (addr >= MVWP_CNT64_BASE && addr < MVWP_CNT64_BASE + 16'h0020)
        begin
            off = addr - MVWP_CNT64_BASE;
            ch = off[4:2];
            unique case (off[1:0]) // descending significance [R06]
                2'h0:    w = MVWP_ZERO_WORD; // top word always zero [R13]
                2'h1:    w = c[ch][47:32];
                2'h2:    w = c[ch][31:16];
                default: w = c[ch][15:0];
            endcase
        end
        else if (addr >= MVWP_FLT_BASE && addr < MVWP_FLT_BASE + 16'h0020)
        begin
            off = addr - MVWP_FLT_BASE;
            ch = off[3:1];
            // float copies of analog values then counters [R09] [R07]
            if (off[4] == 1'b0)
                w = off[0] ? af[ch][15:0] : af[ch][31:16];
            else
                w = off[0] ? cf[ch][15:0] : cf[ch][31:16];
        end
        return w;
    endfunction

    // next reply per connection, from the snapshot or from live data on command start
    always_comb
    begin
        for (int k = 0; k < MVWP_CONN_NUM; k++)
        begin
            next_rsp[k].valid = 1'b0;
            next_rsp[k].data  = 16'h0000;
            // replies only for requested words, never unsolicited [R01] [R02]
            if (req_in[k].word && !req_in[k].start)
            begin
                next_rsp[k].valid = 1'b1;
                next_rsp[k].data  = pick_word(req_in[k].addr, snap_ain[k], snap_cnt[k],
                                              snap_aflt[k], snap_cflt[k], snap_time[k]);
            end
            else if (req_in[k].word && req_in[k].start)
            begin
                // first word comes from live data equal to what the snapshot takes [R15]
                next_rsp[k].valid = 1'b1;
                next_rsp[k].data  = pick_word(req_in[k].addr, ain_in, count_in,
                                              ain_flt_in, count_flt_in, time_in);
            end
        end
    end

    // snapshot registers, refreshed only on command start [R15]
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            for (int k = 0; k < MVWP_CONN_NUM; k++)
            begin
                snap_time[k] <= 32'h00000000;
                rsp_out[k]   <= '0;
                for (int j = 0; j < MVWP_CHAN_NUM; j++)
                begin
                    snap_ain[k][j]  <= 16'h0000;
                    snap_cnt[k][j]  <= 48'h000000000000;
                    snap_aflt[k][j] <= 32'h00000000;
                    snap_cflt[k][j] <= 32'h00000000;
                end
            end
        end
        else
        begin
            for (int k = 0; k < MVWP_CONN_NUM; k++)
            begin
                rsp_out[k] <= next_rsp[k];
                if (req_in[k].start)
                begin
                    snap_time[k] <= time_in;
                    snap_ain[k]  <= ain_in;
                    snap_cnt[k]  <= count_in;
                    snap_aflt[k] <= ain_flt_in;
                    snap_cflt[k] <= count_flt_in;
                end
            end
        end
    end

    // reply is exactly one cycle after each word request [R02]
    property p_reply_timing;
        @(posedge clk_in) disable iff (!rst_b_in)
        req_in[0].word |=> rsp_out[0].valid;
    endproperty
    a_reply_timing: assert property (p_reply_timing) else $error("missing reply"); // [R02]

    property p_silent;
        @(posedge clk_in) disable iff (!rst_b_in)
        !req_in[1].word |=> !rsp_out[1].valid;
    endproperty
    a_silent: assert property (p_silent) else $error("unsolicited reply"); // [R01]

    property p_top_zero;
        @(posedge clk_in) disable iff (!rst_b_in)
        (req_in[0].word && req_in[0].addr >= MVWP_CNT64_BASE
         && req_in[0].addr < MVWP_CNT64_BASE + 16'h0020 && req_in[0].addr[1:0] == 2'h0)
        |=> rsp_out[0].data == 16'h0000;
    endproperty
    a_top_zero: assert property (p_top_zero) else $error("counter top word not zero"); // [R13]

    property p_time_hi;
        @(posedge clk_in) disable iff (!rst_b_in)
        (req_in[0].word && req_in[0].start && req_in[0].addr == MVWP_TIME_ADDR)
        |=> rsp_out[0].data == $past(time_in[31:16]);
    endproperty
    a_time_hi: assert property (p_time_hi) else $error("time high word wrong"); // [R05]

    property p_snap_hold;
        @(posedge clk_in) disable iff (!rst_b_in)
        (req_in[1].word && req_in[1].addr == MVWP_TIME_ADDR + 16'h0001 && !req_in[1].start)
        |=> rsp_out[1].data == $past(snap_time[1][15:0]);
    endproperty
    a_snap_hold: assert property (p_snap_hold) else $error("snapshot not used"); // [R15]

    property p_ain;
        @(posedge clk_in) disable iff (!rst_b_in)
        (req_in[0].word && req_in[0].start && req_in[0].addr == MVWP_AIN_BASE)
        |=> rsp_out[0].data == $past(ain_in[0]);
    endproperty
    a_ain: assert property (p_ain) else $error("analog word wrong"); // [R04]

    // second connection gets its own reply on the same timing
    property p_reply_timing_c1;
        @(posedge clk_in) disable iff (!rst_b_in)
        req_in[1].word |=> rsp_out[1].valid;
    endproperty
    a_reply_timing_c1: assert property (p_reply_timing_c1) else $error("missing reply"); // [R03]

    property p_silent_c0;
        @(posedge clk_in) disable iff (!rst_b_in)
        !req_in[0].word |=> !rsp_out[0].valid;
    endproperty
    a_silent_c0: assert property (p_silent_c0) else $error("unsolicited reply"); // [R02]

    // 32-bit counter high half leads at the lower address
    property p_cnt32_hi;
        @(posedge clk_in) disable iff (!rst_b_in)
        (req_in[1].word && req_in[1].start && req_in[1].addr == MVWP_CNT32_BASE)
        |=> rsp_out[1].data == $past(count_in[0][31:16]);
    endproperty
    a_cnt32_hi: assert property (p_cnt32_hi) else $error("counter high half wrong"); // [R05]

    // two-step time read: high half opens the command, low half follows
    sequence s_time_start;
        req_in[0].word && req_in[0].start && req_in[0].addr == MVWP_TIME_ADDR;
    endsequence

    sequence s_time_low;
        req_in[0].word && !req_in[0].start && req_in[0].addr == MVWP_TIME_ADDR + 16'h0001;
    endsequence

    // low half must come from the copy taken with the high half; live time has moved on
    property p_time_pair;
        @(posedge clk_in) disable iff (!rst_b_in)
        s_time_start ##1 s_time_low |=> rsp_out[0].data == $past(time_in[15:0], 2);
    endproperty
    a_time_pair: assert property (p_time_pair) else $error("time halves torn"); // [R15]
endmodule
`default_nettype wire

// ===== dv/mvwp_client.sv
`timescale 1ns/1ps
`default_nettype none
module mvwp_client
    import mvwp_pkg::*;
(
    input  wire logic      clk_in,
    input  wire mvwp_rsp_s rsp_in,
    output var  mvwp_req_s req_out
);
    // quiet until told to ask; the client starts every exchange
    initial req_out = '0;

    // one word a cycle, reply taken 1 ns after the same edge that takes the word
    task automatic xfer(input logic [15:0] addr, input logic first, output mvwp_rsp_s got);
        req_out = '{first, 1'b1, addr};
        @(posedge clk_in);
        #1;
        got = rsp_in;
    endtask

    // address flips on release so a stale address never looks live
    task automatic idle(output mvwp_rsp_s got);
        req_out = '{1'b0, 1'b0, ~req_out.addr};
        @(posedge clk_in);
        #1;
        got = rsp_in;
    endtask
endmodule
`default_nettype wire

// ===== dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import mvwp_pkg::*;
    localparam logic [15:0] BASE [7] = '{16'h0000, 16'h0080, 16'h0090, 16'h00C0,
                                         16'h0100, 16'h0110, 16'h0120};
    localparam int          STEP [7] = '{1, 2, 0, 4, 2, 2, 1};
    localparam int          LEN  [7] = '{1, 2, 2, 4, 2, 2, 1};
    localparam logic [15:0] CORNER [8] = '{16'h0007, 16'h0008, 16'h008F, 16'h0092,
                                           16'h00BF, 16'h00E0, 16'h011F, 16'hFFFF};
    logic        clk_in;
    logic        rst_b_in;
    logic [15:0] ain  [MVWP_CHAN_NUM];
    logic [47:0] cnt  [MVWP_CHAN_NUM];
    logic [31:0] aflt [MVWP_CHAN_NUM];
    logic [31:0] cflt [MVWP_CHAN_NUM];
    logic [31:0] secs;
    logic [15:0] p_a  [MVWP_CHAN_NUM];
    logic [47:0] p_c  [MVWP_CHAN_NUM];
    logic [31:0] p_af [MVWP_CHAN_NUM];
    logic [31:0] p_cf [MVWP_CHAN_NUM];
    logic [31:0] p_t;
    mvwp_req_s   req  [MVWP_CONN_NUM];
    mvwp_rsp_s   rsp  [MVWP_CONN_NUM];
    int          fails;
    int          n_checks;

    mvwp_packer uut (.clk_in(clk_in), .rst_b_in(rst_b_in), .ain_in(ain), .count_in(cnt),
        .ain_flt_in(aflt), .count_flt_in(cflt), .time_in(secs), .req_in(req), .rsp_out(rsp));
    mvwp_client cl0 (.clk_in(clk_in), .rsp_in(rsp[0]), .req_out(req[0]));
    mvwp_client cl1 (.clk_in(clk_in), .rsp_in(rsp[1]), .req_out(req[1]));

    initial
    begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    // inputs as the design saw them at the last edge
    always @(posedge clk_in)
    begin
        p_a <= ain;
        p_c <= cnt;
        p_af <= aflt;
        p_cf <= cflt;
        p_t <= secs;
    end

    // measurements move every cycle so a torn snapshot shows up
    initial
    begin
        ain = '{default: 16'h0000};
        cnt = '{default: 48'h0};
        aflt = '{default: 32'h0};
        cflt = '{default: 32'h0};
        secs = 32'h0;
        forever
        begin
            @(posedge clk_in);
            #1;
            foreach (ain[n])
            begin
                ain[n] = 16'($urandom);
                cnt[n] = {16'($urandom), $urandom};
                aflt[n] = $urandom;
                cflt[n] = $urandom;
            end
            secs = $urandom;
        end
    end

    // expected register word, from the values caught at the start edge
    function automatic logic [15:0] word_of(input logic [15:0] a);
        logic [63:0] v;
        if (a < 16'h0008)
            return p_a[a[2:0]];
        if (a[15:5] == 11'h006)
        begin
            v = {16'h0000, p_c[a[4:2]]};
            return v[{2'h3 - a[1:0], 4'h0} +: 16];
        end
        if (a[15:4] == 12'h008)
            v = {32'h0, p_c[a[3:1]][31:0]};
        else if (a[15:1] == 15'h0048)
            v = {32'h0, p_t};
        else if (a[15:5] == 11'h008)
            v = {32'h0, a[4] ? p_cf[a[3:1]] : p_af[a[3:1]]};
        else
            return MVWP_UNDEF_WORD;
        return a[0] ? v[15:0] : v[31:16];
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // whole value in one command, then one idle cycle
    task automatic cmd(input int k, input logic [15:0] base, input int len);
        mvwp_rsp_s   got;
        logic [15:0] exp [4];
        for (int j = 0; j < len; j++)
        begin
            if (k == 0)
                cl0.xfer(base + 16'(j), j == 0, got);
            else
                cl1.xfer(base + 16'(j), j == 0, got);
            if (j == 0)
                foreach (exp[m])
                    exp[m] = word_of(base + 16'(m));
            chk({15'h0000, got.valid}, 16'h0001);
            chk(got.data, exp[j]);
        end
        if (k == 0)
            cl0.idle(got);
        else
            cl1.idle(got);
        chk({15'h0000, got.valid}, 16'h0000);
    endtask

    task automatic rnd(input int k);
        int t;
        t = $urandom_range(6);
        cmd(k, BASE[t] + 16'(STEP[t] * $urandom_range(7)), LEN[t]);
    endtask

    task automatic end_sim();
        if (fails == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial
    begin
        void'($urandom(32'hD119));
        fails = 0;
        n_checks = 0;
        rst_b_in = 1'b0;
        repeat (8) @(posedge clk_in);
        #1;
        chk(rsp[0].data | rsp[1].data, 16'h0000);
        chk({14'h0000, rsp[0].valid, rsp[1].valid}, 16'h0000);
        rst_b_in = 1'b1;
        @(posedge clk_in);
        #1;
        foreach (CORNER[e])
            cmd(0, CORNER[e], 1);
        for (int i = 0; i < 7; i++)
        begin
            cmd(0, BASE[i], LEN[i]);
            cmd(1, BASE[i], LEN[i]);
        end
        repeat (60)
        begin
            fork
                rnd(0);
                rnd(1);
            join
        end
        end_sim();
    end
endmodule
`default_nettype wire
